// >>> pkg/ces_regs.svh
// Register offsets, field positions, reset values and masks of the comparator event slice.
// Function
// (RQ1) Select 11: event on any output change.
// (RQ2) Select 10: event on adjusted falling edge.
// (RQ3) Invert set: detect on complemented comparator output.
// (RQ4) Invert clear: detect on raw comparator output.
// (RQ5) Select 01: event on adjusted rising edge.
// (RQ6) Select 00: never any trigger or event.
// (RQ7) Events only while event flag is clear.
// (RQ8) Reference bit picks internal reference or pin.
// (RQ9) Channel 00 pin one, 01 pin two.
// (RQ10) Bits 5 and 3-2 read zero.
// (RQ11) Amplifier mode blocks pin two selection.
// (RQ12) Event sets flag until software clears it.
`ifndef CES_REGS_SVH
`define CES_REGS_SVH

`define CES_CTRL_OFS      8'h00
`define CES_STAT_OFS      8'h04
`define CES_MASK_OFS      8'h08
`define CES_LIVE_OFS      8'h0C

`define CES_CTRL_RESET    16'h0000
`define CES_CTRL_WMASK    16'h84D3
`define CES_STAT_RESET    2'h0
`define CES_MASK_RESET    2'h0

`define CES_CH_LSB        0
`define CES_REF_BIT       4
`define CES_EDGE_LSB      6
`define CES_AMP_BIT       10
`define CES_INV_BIT       15

`define CES_STAT_EVENT    0
`define CES_STAT_BLOCKED  1

`endif

// >>> pkg/ces_pkg.sv
// Types shared by the comparator event slice.
`default_nettype none
package ces_pkg;
  typedef enum logic [1:0] {
    CES_EDGE_NONE    = 2'h0,
    CES_EDGE_RISE    = 2'h1,
    CES_EDGE_FALL    = 2'h2,
    CES_EDGE_ANY     = 2'h3
  } ces_edge_type;

  typedef enum logic [1:0] {
    CES_CH_PIN_ONE   = 2'h0,
    CES_CH_PIN_TWO   = 2'h1,
    CES_CH_UNUSED_A  = 2'h2,
    CES_CH_UNUSED_B  = 2'h3
  } ces_channel_type;

  typedef enum logic [1:0] {
    CES_BUS_IDLE     = 2'h0,
    CES_BUS_ACK      = 2'h1
  } ces_bus_type;
endpackage : ces_pkg
`default_nettype wire

// >>> verilog/ces_edge_detect.sv
// Polarity-adjusted edge qualifier for the comparator output.
`default_nettype none
module ces_edge_detect
  import ces_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         cmp_in,
  input  wire logic         invert_in,
  input  wire ces_edge_type edge_sel_in,
  output logic              edge_out
);
  logic prev_reg;
  logic prev_next;
  logic edge_reg;
  logic edge_next;
  logic adj_now;
  logic adj_prev;

  // Both samples pass through the same inversion, so writing the invert bit
  // alone never looks like an edge.
  always_comb begin
    adj_now   = cmp_in ^ invert_in;   // [RQ3] [RQ4]
    adj_prev  = prev_reg ^ invert_in; // [RQ3] [RQ4]
    prev_next = cmp_in;
    case (edge_sel_in)
      CES_EDGE_NONE: edge_next = 1'b0;                 // [RQ6]
      CES_EDGE_RISE: edge_next = adj_now & ~adj_prev;  // [RQ5]
      CES_EDGE_FALL: edge_next = ~adj_now & adj_prev;  // [RQ2]
      CES_EDGE_ANY:  edge_next = adj_now ^ adj_prev;   // [RQ1]
      default:       edge_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_reg <= 1'b0;
      edge_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      edge_reg <= edge_next;
    end
  end

  assign edge_out = edge_reg;

  a_none_silent: assert property (@(posedge clk_in) disable iff (rst_in)
    (edge_sel_in == CES_EDGE_NONE) |=> !edge_out) // [RQ6]
    else $error("Edge raised while detection disabled.");

  a_rise_only: assert property (@(posedge clk_in) disable iff (rst_in)
    (edge_sel_in == CES_EDGE_RISE) && (cmp_in ^ invert_in) && !(prev_reg ^ invert_in)
    |=> edge_out) // [RQ5]
    else $error("Adjusted rising edge was missed.");

  a_fall_only: assert property (@(posedge clk_in) disable iff (rst_in)
    (edge_sel_in == CES_EDGE_FALL) && (cmp_in ^ invert_in) |=> !edge_out) // [RQ2]
    else $error("Edge raised without an adjusted falling edge.");

  a_any_change: assert property (@(posedge clk_in) disable iff (rst_in)
    (edge_sel_in == CES_EDGE_ANY) && (cmp_in != prev_reg) |=> edge_out) // [RQ1]
    else $error("Change of comparator output was missed.");

  a_invert_rise: assert property (@(posedge clk_in) disable iff (rst_in)
    (edge_sel_in == CES_EDGE_FALL) && invert_in && cmp_in && !prev_reg |=> edge_out) // [RQ3]
    else $error("Inverted falling edge did not fire on raw rise.");

  a_raw_rise: assert property (@(posedge clk_in) disable iff (rst_in)
    (edge_sel_in == CES_EDGE_RISE) && !invert_in && !cmp_in |=> !edge_out) // [RQ4]
    else $error("Raw rising detection fired on a low output.");
endmodule : ces_edge_detect
`default_nettype wire

// >>> verilog/ces_top.sv
// Comparator event slice: control registers, event flag and interrupt on classic Wishbone.
//
// Chosen here: the register offsets and the Wishbone slave port.
`include "ces_regs.svh"
`default_nettype none
module ces_top
  import ces_pkg::*;
(
  input  wire logic         CLK_SYS_IN,
  input  wire logic         SYS_RST_IN,
  input  wire logic         WB_CYC_IN,
  input  wire logic         WB_STB_IN,
  input  wire logic         WB_WE_IN,
  input  wire logic [7:0]   WB_ADR_IN,
  input  wire logic [3:0]   WB_SEL_IN,
  input  wire logic [31:0]  WB_DAT_IN,
  output logic [31:0]       WB_DAT_OUT,
  output logic              WB_ACK_OUT,
  input  wire logic         CMP_OUT_IN,
  output logic              EVENT_OUT,
  output logic              IRQ_OUT,
  output logic              PLUS_REF_SEL_OUT,
  output logic              PLUS_PIN_ONE_SEL_OUT,
  output logic              MINUS_PIN_ONE_SEL_OUT,
  output logic              MINUS_PIN_TWO_SEL_OUT,
  output logic              AMP_MODE_OUT
);

  // Merges the enabled byte lanes of a write into a register value.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  ces_bus_type     bus_reg;
  ces_bus_type     bus_next;
  logic [31:0]     rdata_reg;
  logic [31:0]     rdata_next;
  logic [15:0]     ctrl_reg;
  logic [15:0]     ctrl_next;
  logic [1:0]      stat_reg;
  logic [1:0]      stat_next;
  logic [1:0]      mask_reg;
  logic [1:0]      mask_next;
  logic            event_reg;
  logic            event_next;
  logic            irq_reg;
  logic            irq_next;
  logic            plus_ref_reg;
  logic            plus_ref_next;
  logic            plus_pin_reg;
  logic            plus_pin_next;
  logic            minus_one_reg;
  logic            minus_one_next;
  logic            minus_two_reg;
  logic            minus_two_next;
  logic            amp_reg;
  logic            amp_next;
  logic            cmp_seen_reg;
  logic            cmp_seen_next;

  logic            wb_req;
  logic            wb_write;
  logic [31:0]     wdata_merged;
  logic [31:0]     ctrl_view;
  logic            qual_edge;
  logic            fire;
  ces_edge_type    edge_sel;
  ces_channel_type chan_sel;

  assign wb_req   = WB_CYC_IN & WB_STB_IN;
  // The write lands on the edge at which the master samples ack.
  assign wb_write = wb_req & WB_WE_IN & (bus_reg == CES_BUS_ACK);
  assign edge_sel = ces_edge_type'(ctrl_reg[`CES_EDGE_LSB +: 2]);
  assign chan_sel = ces_channel_type'(ctrl_reg[`CES_CH_LSB +: 2]);

  ces_edge_detect ces_edge_detect_inst (
    .clk_in      (CLK_SYS_IN),
    .rst_in      (SYS_RST_IN),
    .cmp_in      (CMP_OUT_IN),
    .invert_in   (ctrl_reg[`CES_INV_BIT]), // [RQ3] [RQ4]
    .edge_sel_in (edge_sel),
    .edge_out    (qual_edge)
  );

  // Control view: the unimplemented bits are masked out so they read zero.
  always_comb begin
    ctrl_view = {16'h0000, ctrl_reg & `CES_CTRL_WMASK}; // [RQ10]
  end

  // Bus handshake: one wait state, ack for a single cycle.
  always_comb begin
    bus_next   = bus_reg;
    rdata_next = 32'h0000_0000;
    case (bus_reg)
      CES_BUS_IDLE: begin
        if (wb_req) begin
          bus_next = CES_BUS_ACK;
          case (WB_ADR_IN)
            `CES_CTRL_OFS: rdata_next = ctrl_view; // [RQ10]
            `CES_STAT_OFS: rdata_next = {30'h0000_0000, stat_reg};
            `CES_MASK_OFS: rdata_next = {30'h0000_0000, mask_reg};
            `CES_LIVE_OFS: rdata_next = {30'h0000_0000, cmp_seen_reg, qual_edge};
            default:       rdata_next = 32'h0000_0000;
          endcase
        end
      end
      CES_BUS_ACK: bus_next = CES_BUS_IDLE;
      default:     bus_next = CES_BUS_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      bus_reg   <= CES_BUS_IDLE;
      rdata_reg <= 32'h0000_0000;
    end else begin
      bus_reg   <= bus_next;
      rdata_reg <= rdata_next;
    end
  end

  // The acknowledge state is the only one with bit 0 set, so ack comes straight off a flop.
  assign WB_ACK_OUT = bus_reg[0];
  assign WB_DAT_OUT = rdata_reg;

  // Register writes, event flag and interrupt.
  always_comb begin
    ctrl_next     = ctrl_reg;
    mask_next     = mask_reg;
    wdata_merged  = 32'h0000_0000;
    cmp_seen_next = CMP_OUT_IN;
    // A new event is taken only while the flag is clear.
    fire          = qual_edge & ~stat_reg[`CES_STAT_EVENT]; // [RQ7]
    event_next    = fire;
    stat_next     = stat_reg;
    if (wb_write) begin
      case (WB_ADR_IN)
        `CES_CTRL_OFS: begin
          wdata_merged = merge_bytes({16'h0000, ctrl_reg}, WB_DAT_IN, WB_SEL_IN);
          ctrl_next    = wdata_merged[15:0] & `CES_CTRL_WMASK; // [RQ10]
        end
        `CES_STAT_OFS: begin
          if (WB_SEL_IN[0]) begin
            stat_next = stat_reg & ~WB_DAT_IN[1:0];
          end
        end
        `CES_MASK_OFS: begin
          if (WB_SEL_IN[0]) begin
            mask_next = WB_DAT_IN[1:0];
          end
        end
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle.
    if (fire) begin
      stat_next[`CES_STAT_EVENT] = 1'b1; // [RQ12]
    end
    if (qual_edge & stat_reg[`CES_STAT_EVENT]) begin
      stat_next[`CES_STAT_BLOCKED] = 1'b1; // [RQ7]
    end
    irq_next = |(stat_next & mask_next);
  end

  // Analog routing selects; channel codes with no input leave both minus-input switches open.
  always_comb begin
    amp_next       = ctrl_reg[`CES_AMP_BIT];
    plus_ref_next  = ctrl_reg[`CES_REF_BIT];  // [RQ8]
    plus_pin_next  = ~ctrl_reg[`CES_REF_BIT]; // [RQ8]
    minus_one_next = (chan_sel == CES_CH_PIN_ONE); // [RQ9]
    // Pin two is unavailable to the amplifier, so it stays disconnected there.
    minus_two_next = (chan_sel == CES_CH_PIN_TWO) & ~ctrl_reg[`CES_AMP_BIT]; // [RQ9] [RQ11]
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      ctrl_reg      <= `CES_CTRL_RESET;
      stat_reg      <= `CES_STAT_RESET;
      mask_reg      <= `CES_MASK_RESET;
      event_reg     <= 1'b0;
      irq_reg       <= 1'b0;
      cmp_seen_reg  <= 1'b0;
      plus_ref_reg  <= 1'b0;
      plus_pin_reg  <= 1'b1;
      minus_one_reg <= 1'b1;
      minus_two_reg <= 1'b0;
      amp_reg       <= 1'b0;
    end else begin
      ctrl_reg      <= ctrl_next;
      stat_reg      <= stat_next;
      mask_reg      <= mask_next;
      event_reg     <= event_next;
      irq_reg       <= irq_next;
      cmp_seen_reg  <= cmp_seen_next;
      plus_ref_reg  <= plus_ref_next;
      plus_pin_reg  <= plus_pin_next;
      minus_one_reg <= minus_one_next;
      minus_two_reg <= minus_two_next;
      amp_reg       <= amp_next;
    end
  end

  assign EVENT_OUT             = event_reg;
  assign IRQ_OUT               = irq_reg;
  assign PLUS_REF_SEL_OUT      = plus_ref_reg;
  assign PLUS_PIN_ONE_SEL_OUT  = plus_pin_reg;
  assign MINUS_PIN_ONE_SEL_OUT = minus_one_reg;
  assign MINUS_PIN_TWO_SEL_OUT = minus_two_reg;
  assign AMP_MODE_OUT          = amp_reg;

  a_flag_blocks: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    stat_reg[`CES_STAT_EVENT] |=> !EVENT_OUT) // [RQ7]
    else $error("Event raised while the event flag was set.");

  a_event_sets: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    qual_edge && !stat_reg[`CES_STAT_EVENT] |=> EVENT_OUT && stat_reg[`CES_STAT_EVENT]) // [RQ12]
    else $error("Qualifying edge did not set the flag and pulse the event.");

  a_flag_holds: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    stat_reg[`CES_STAT_EVENT] && !(wb_write && WB_ADR_IN == `CES_STAT_OFS)
    |=> stat_reg[`CES_STAT_EVENT]) // [RQ12]
    else $error("Event flag fell without a software clear.");

  a_ref_route: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    1'b1 |=> PLUS_REF_SEL_OUT == $past(ctrl_reg[`CES_REF_BIT])
             && PLUS_PIN_ONE_SEL_OUT != PLUS_REF_SEL_OUT) // [RQ8]
    else $error("Non-inverting input routing disagrees with reference bit.");

  a_amp_no_pin2: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    ctrl_reg[`CES_AMP_BIT] |=> !MINUS_PIN_TWO_SEL_OUT) // [RQ11]
    else $error("Pin two selected while in amplifier mode.");

  a_chan_route: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    chan_sel[1] |=> !MINUS_PIN_ONE_SEL_OUT && !MINUS_PIN_TWO_SEL_OUT) // [RQ9]
    else $error("Unimplemented channel code closed an input switch.");

  a_reserved_zero: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    WB_ACK_OUT && $past(WB_ADR_IN) == `CES_CTRL_OFS
    |-> WB_DAT_OUT[5] == 1'b0 && WB_DAT_OUT[3:2] == 2'h0) // [RQ10]
    else $error("Unimplemented control bits read back nonzero.");

  a_ack_single: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("Ack held longer than one cycle.");

  a_ack_timing: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("Request was not acknowledged after one wait state.");

  a_idle_data: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    !WB_ACK_OUT |-> WB_DAT_OUT == 32'h0000_0000)
    else $error("Read data nonzero outside an acknowledge.");

  a_irq_level: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    IRQ_OUT == |(stat_reg & mask_reg))
    else $error("Interrupt level disagrees with status and mask.");

  a_blocked_set: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    qual_edge && stat_reg[`CES_STAT_EVENT] |=> stat_reg[`CES_STAT_BLOCKED]) // [RQ7]
    else $error("Edge held back by the flag was not recorded.");

  a_event_single: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    EVENT_OUT |=> !EVENT_OUT) // [RQ7]
    else $error("Event pulse lasted longer than one cycle.");

  a_flag_clear: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    wb_write && WB_ADR_IN == `CES_STAT_OFS && WB_SEL_IN[0] && WB_DAT_IN[0] && !fire
    |=> !stat_reg[`CES_STAT_EVENT]) // [RQ12]
    else $error("Software clear of the event flag did not take.");

  a_mask_write: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    wb_write && WB_ADR_IN == `CES_MASK_OFS && WB_SEL_IN[0]
    |=> mask_reg == $past(WB_DAT_IN[1:0]))
    else $error("Mask write did not land.");

  a_amp_follow: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    1'b1 |=> AMP_MODE_OUT == $past(ctrl_reg[`CES_AMP_BIT])) // [RQ11]
    else $error("Amplifier mode output does not follow its control bit.");

  a_pin_one_route: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    chan_sel == CES_CH_PIN_ONE |=> MINUS_PIN_ONE_SEL_OUT && !MINUS_PIN_TWO_SEL_OUT) // [RQ9]
    else $error("Channel code 00 did not route pin one alone.");

  a_pin_two_route: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    chan_sel == CES_CH_PIN_TWO && !ctrl_reg[`CES_AMP_BIT]
    |=> MINUS_PIN_TWO_SEL_OUT && !MINUS_PIN_ONE_SEL_OUT) // [RQ9]
    else $error("Channel code 01 did not route pin two alone.");

  c_event_fired: cover property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    EVENT_OUT);
  c_edge_blocked: cover property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    qual_edge && stat_reg[`CES_STAT_EVENT]);
  c_irq_raised: cover property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    !IRQ_OUT ##1 IRQ_OUT);
  c_set_meets_clear: cover property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    fire && wb_write && WB_ADR_IN == `CES_STAT_OFS);
  c_inverted_event: cover property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    ctrl_reg[`CES_INV_BIT] && EVENT_OUT);
endmodule : ces_top
`default_nettype wire

// >>> verif/tb_ces_top.sv
// Self-checking bench for the comparator event slice.
`include "ces_regs.svh"
`default_nettype none
module tb_ces_top
  import ces_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [3:0]  sel;
    logic [15:0] wdat;
    logic [15:0] rb;
    logic [4:0]  route;
  } ces_rcase_type;

  typedef struct packed {
    ces_edge_type esel;
    logic         inv;
    logic         from_lvl;
    logic         to_lvl;
    logic         fire;
  } ces_erow_type;

  logic        clk_sys;
  logic        sys_rst;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        cmp_raw;
  logic        event_pulse;
  logic        irq;
  logic [4:0]  route;
  int          mismatches;
  int          samples_checked;
  int          ev_cnt;
  int          cycles;

  // Route order: reference, plus pin one, minus pin one, minus pin two, amplifier.
  ces_rcase_type rcases [7] = '{
    '{4'hF, 16'h0001, 16'h0001, 5'h0A}, '{4'hF, 16'h0011, 16'h0011, 5'h12},
    '{4'hF, 16'h0411, 16'h0411, 5'h11}, '{4'hF, 16'hFFFF, 16'h84D3, 5'h11},
    '{4'hF, 16'h0000, 16'h0000, 5'h0C}, '{4'h2, 16'hFFFF, 16'h8400, 5'h0D},
    '{4'h1, 16'hFFFF, 16'h84D3, 5'h11}};

  // Row fields: edge select, invert, level before, level after, event expected.
  ces_erow_type erows [11] = '{
    '{CES_EDGE_NONE, 1'b0, 1'b0, 1'b1, 1'b0}, '{CES_EDGE_NONE, 1'b0, 1'b1, 1'b0, 1'b0},
    '{CES_EDGE_RISE, 1'b0, 1'b0, 1'b1, 1'b1}, '{CES_EDGE_RISE, 1'b0, 1'b1, 1'b0, 1'b0},
    '{CES_EDGE_FALL, 1'b0, 1'b0, 1'b1, 1'b0}, '{CES_EDGE_FALL, 1'b0, 1'b1, 1'b0, 1'b1},
    '{CES_EDGE_FALL, 1'b1, 1'b0, 1'b1, 1'b1}, '{CES_EDGE_FALL, 1'b1, 1'b1, 1'b0, 1'b0},
    '{CES_EDGE_RISE, 1'b1, 1'b1, 1'b0, 1'b1},
    '{CES_EDGE_ANY,  1'b0, 1'b0, 1'b1, 1'b1}, '{CES_EDGE_ANY,  1'b0, 1'b1, 1'b0, 1'b1}};

  ces_top ces_top_inst (
    .CLK_SYS_IN            (clk_sys),
    .SYS_RST_IN            (sys_rst),
    .WB_CYC_IN             (wb_cyc),
    .WB_STB_IN             (wb_stb),
    .WB_WE_IN              (wb_we),
    .WB_ADR_IN             (wb_adr),
    .WB_SEL_IN             (wb_sel),
    .WB_DAT_IN             (wb_wdat),
    .WB_DAT_OUT            (wb_rdat),
    .WB_ACK_OUT            (wb_ack),
    .CMP_OUT_IN            (cmp_raw),
    .EVENT_OUT             (event_pulse),
    .IRQ_OUT               (irq),
    .PLUS_REF_SEL_OUT      (route[4]),
    .PLUS_PIN_ONE_SEL_OUT  (route[3]),
    .MINUS_PIN_ONE_SEL_OUT (route[2]),
    .MINUS_PIN_TWO_SEL_OUT (route[1]),
    .AMP_MODE_OUT          (route[0])
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Registered outputs only move on the rising edge, so the falling edge sees them settled.
  always @(negedge clk_sys) begin
    if (event_pulse === 1'b1) ev_cnt = ev_cnt + 1;
  end

  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      mismatches = mismatches + 1;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // The request stands until the rising edge that sees ack; data is taken at that edge.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                    input logic [31:0] wdat, output logic [31:0] rdat);
    @(posedge clk_sys);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_sel  <= sel;
    wb_wdat <= wdat;
    do @(posedge clk_sys); while (wb_ack !== 1'b1);
    rdat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] wdat);
    logic [31:0] unused;
    wb(1'b1, adr, sel, wdat, unused);
  endtask : wr

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rdat;
    wb(1'b0, adr, 4'hF, 32'h0000_0000, rdat);
    check(rdat, exp);
  endtask : rd_chk

  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : settle

  task automatic toggle_cmp();
    @(posedge clk_sys);
    cmp_raw <= ~cmp_raw;
    settle(5);
  endtask : toggle_cmp

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    {wb_cyc, wb_stb, wb_we, cmp_raw} <= 4'h0;
    wb_adr  <= 8'h00;
    wb_sel  <= 4'h0;
    wb_wdat <= 32'h0000_0000;
    sys_rst <= 1'b1;
    mismatches = 0;
    samples_checked = 0;
    ev_cnt = 0;
    cycles = 0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle(1);
    check({27'h0, route}, 32'h0000_000C);
    check({30'h0, event_pulse, irq}, 32'h0000_0000);
    rd_chk(`CES_CTRL_OFS, 32'h0000_0000);
    foreach (rcases[i]) begin
      wr(`CES_CTRL_OFS, rcases[i].sel, {16'h0000, rcases[i].wdat});
      settle(2);
      check({27'h0, route}, {27'h0, rcases[i].route});
      rd_chk(`CES_CTRL_OFS, {16'h0000, rcases[i].rb});
    end
    rd_chk(8'h10, 32'h0000_0000);
    wr(8'h10, 4'hF, 32'hFFFF_FFFF);
    rd_chk(`CES_CTRL_OFS, 32'h0000_84D3);
    wr(`CES_MASK_OFS, 4'hF, 32'h0000_0001);
    foreach (erows[i]) begin
      @(posedge clk_sys);
      cmp_raw <= erows[i].from_lvl;
      settle(5);
      wr(`CES_CTRL_OFS, 4'hF,
         (32'(erows[i].inv) << `CES_INV_BIT) | (32'(erows[i].esel) << `CES_EDGE_LSB));
      wr(`CES_STAT_OFS, 4'hF, 32'h0000_0003);
      ev_cnt = 0;
      @(posedge clk_sys);
      cmp_raw <= erows[i].to_lvl;
      settle(5);
      check(32'(ev_cnt), {31'h0, erows[i].fire});
      check({31'h0, irq}, {31'h0, erows[i].fire});
      rd_chk(`CES_STAT_OFS, {31'h0, erows[i].fire});
    end
    // Flag is still set from the last row, so further edges must be held back.
    ev_cnt = 0;
    toggle_cmp();
    toggle_cmp();
    check(32'(ev_cnt), 32'h0000_0000);
    rd_chk(`CES_STAT_OFS, 32'h0000_0003);
    wr(`CES_MASK_OFS, 4'hF, 32'h0000_0000);
    settle(2);
    check({31'h0, irq}, 32'h0000_0000);
    wr(`CES_MASK_OFS, 4'hF, 32'h0000_0001);
    wr(`CES_STAT_OFS, 4'hF, 32'h0000_0001);
    settle(2);
    check({31'h0, irq}, 32'h0000_0000);
    rd_chk(`CES_STAT_OFS, 32'h0000_0002);
    toggle_cmp();
    check(32'(ev_cnt), 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0001);
    // Reset in mid-run with the flag set and the comparator high must not leave an event.
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle(1);
    check({27'h0, route}, 32'h0000_000C);
    check({30'h0, event_pulse, irq}, 32'h0000_0000);
    rd_chk(`CES_STAT_OFS, 32'h0000_0000);
    rd_chk(`CES_CTRL_OFS, 32'h0000_0000);
    settle(3);
    check({30'h0, event_pulse, irq}, 32'h0000_0000);
    wrap_up();
  end
endmodule : tb_ces_top
`default_nettype wire
